// ===== rtl/cfs_pkg.sv
// Package: offsets, reset values and carriers for the fault status latches
package cfs_pkg;
  // ********************************************************
  // Geometry
  // ********************************************************
  localparam int NUM_CH = 8;
  localparam int SEQ_W_DEF = 8;

  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [7:0] OFS_MONITOR_SUM = 8'h11;
  localparam logic [7:0] OFS_HF_UNDER = 8'h12;
  localparam logic [7:0] OFS_LF_UNDER = 8'h14;
  localparam logic [7:0] OFS_HF_OVER = 8'h16;
  localparam logic [7:0] OFS_LF_OVER = 8'h18;
  localparam logic [7:0] OFS_POWERON_ORDER = 8'h1A;

  // ********************************************************
  // Reset values and summary bit positions
  // ********************************************************
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam int SUM_HF_UNDER = 0;
  localparam int SUM_LF_UNDER = 1;
  localparam int SUM_HF_OVER = 2;
  localparam int SUM_LF_OVER = 3;
  localparam int SUM_POWERON = 7;

  // ********************************************************
  // Carriers
  // ********************************************************
  // Comparator levels, one bit per channel, high while the fault holds
  typedef struct packed {
    logic [7:0] hf_under;
    logic [7:0] lf_under;
    logic [7:0] hf_over;
    logic [7:0] lf_over;
  } cfs_cond_t;

  // Per-type interrupt enables, one bit per channel
  typedef struct packed {
    logic [7:0] hf_under;
    logic [7:0] lf_under;
    logic [7:0] hf_over;
    logic [7:0] lf_over;
    logic [7:0] poweron;
  } cfs_enable_t;

  // Register port from the serial interface engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfs_reg_req_t;
endpackage : cfs_pkg

// ===== rtl/cfs_fault_bank.sv
// One 8-channel bank of sticky write-1-to-clear fault bits
`timescale 1ns/10ps
module cfs_fault_bank #(
  parameter int CH_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Per-channel requests
  input wire logic [CH_W-1:0] set_req,
  input wire logic [CH_W-1:0] clr_req,
  // Latched state
  output logic [CH_W-1:0] status
);
  // ********************************************************
  // Elaboration check
  // ********************************************************
  if (CH_W < 1 || CH_W > 8) begin : g_bad_width
    $error("cfs_fault_bank: CH_W must be 1 to 8");
  end

  // ********************************************************
  // Per-channel latches
  // ********************************************************
  for (genvar i = 0; i < CH_W; i++) begin : g_ch
    // Set outranks clear so an event in the clearing cycle survives
    always_ff @(posedge core_clk) begin
      if (rst) begin
        status[i] <= 1'b0;
      end else if (set_req[i]) begin
        status[i] <= 1'b1;
      end else if (clr_req[i]) begin
        status[i] <= 1'b0;
      end
    end
  end
endmodule : cfs_fault_bank

// ===== rtl/cfs_fault_latches.sv
// Top of the per-channel fault status latches with summary and interrupt
//
// Overview of operation
// (RULE1) HF undervoltage sets its channel bit
// (RULE2) HF undervoltage clear needs condition gone
// (RULE3) LF undervoltage sets its channel bit
// (RULE4) LF undervoltage clear needs condition gone
// (RULE5) HF overvoltage sets its channel bit
// (RULE6) HF overvoltage clear needs condition gone
// (RULE7) LF overvoltage sets its channel bit
// (RULE8) LF overvoltage clear needs condition gone
// (RULE9) Fault bits sticky; only host write clears
// (RULE10) Sequence record mismatch sets channel bit
// (RULE11) Sequence bit clears unconditionally on write
// (RULE12) Disabled channel bit reads as zero
// (RULE13) Eight-bit registers, read with write-1-clear
// (RULE14) Summary bits 0-3 OR each voltage register
// (RULE15) Summary bit 7 ORs sequence register
// (RULE16) Interrupt low while any enabled bit set
`timescale 1ns/10ps
module cfs_fault_latches #(
  parameter int SEQ_W = cfs_pkg::SEQ_W_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire cfs_pkg::cfs_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Monitor comparator levels and interrupt enables
  input wire cfs_pkg::cfs_cond_t fault_cond,
  input wire cfs_pkg::cfs_enable_t irq_enable,
  // Power-on sequence results, checked on a one-cycle strobe
  input wire logic seq_check,
  input wire logic [cfs_pkg::NUM_CH*SEQ_W-1:0] poweron_order_record,
  input wire logic [cfs_pkg::NUM_CH*SEQ_W-1:0] poweron_order_expected,
  // Summary and open-drain interrupt pin
  output logic [7:0] monitor_summary,
  output logic interrupt_out_n,
  output logic interrupt_out_n_oe_n
);
  localparam int NCH = cfs_pkg::NUM_CH;

  // ********************************************************
  // Elaboration check
  // ********************************************************
  if (SEQ_W < 1 || SEQ_W > 16) begin : g_bad_seq
    $error("cfs_fault_latches: SEQ_W must be 1 to 16");
  end

  // ********************************************************
  // Register decode
  // ********************************************************
  logic wr_hf_under;
  logic wr_lf_under;
  logic wr_hf_over;
  logic wr_lf_over;
  logic wr_poweron;
  // Write strobes per status register
  assign wr_hf_under = reg_req.wr && reg_req.addr == cfs_pkg::OFS_HF_UNDER;
  assign wr_lf_under = reg_req.wr && reg_req.addr == cfs_pkg::OFS_LF_UNDER;
  assign wr_hf_over = reg_req.wr && reg_req.addr == cfs_pkg::OFS_HF_OVER;
  assign wr_lf_over = reg_req.wr && reg_req.addr == cfs_pkg::OFS_LF_OVER;
  assign wr_poweron = reg_req.wr
    && reg_req.addr == cfs_pkg::OFS_POWERON_ORDER;

  // ********************************************************
  // Sequence comparison
  // ********************************************************
  logic [NCH-1:0] seq_mismatch;
  // (RULE10) record versus expected
  for (genvar c = 0; c < NCH; c++) begin : g_seq
    assign seq_mismatch[c] =
      poweron_order_record[c*SEQ_W +: SEQ_W]
      != poweron_order_expected[c*SEQ_W +: SEQ_W];
  end

  // ********************************************************
  // Set and clear requests
  // ********************************************************
  logic [NCH-1:0] hfu_set;
  logic [NCH-1:0] lfu_set;
  logic [NCH-1:0] hfo_set;
  logic [NCH-1:0] lfo_set;
  logic [NCH-1:0] seq_set;
  logic [NCH-1:0] hfu_clr;
  logic [NCH-1:0] lfu_clr;
  logic [NCH-1:0] hfo_clr;
  logic [NCH-1:0] lfo_clr;
  logic [NCH-1:0] seq_clr;
  // (RULE1) trip on enabled HF under
  assign hfu_set = fault_cond.hf_under & irq_enable.hf_under;
  // (RULE3) trip on enabled LF under
  assign lfu_set = fault_cond.lf_under & irq_enable.lf_under;
  // (RULE5) trip on enabled HF over
  assign hfo_set = fault_cond.hf_over & irq_enable.hf_over;
  // (RULE7) trip on enabled LF over
  assign lfo_set = fault_cond.lf_over & irq_enable.lf_over;
  // (RULE10) trip on checked mismatch
  assign seq_set = {NCH{seq_check}} & seq_mismatch & irq_enable.poweron;
  // (RULE2) clear blocked while high
  assign hfu_clr = {NCH{wr_hf_under}} & reg_req.wdata & ~fault_cond.hf_under;
  // (RULE4) clear blocked while high
  assign lfu_clr = {NCH{wr_lf_under}} & reg_req.wdata & ~fault_cond.lf_under;
  // (RULE6) clear blocked while high
  assign hfo_clr = {NCH{wr_hf_over}} & reg_req.wdata & ~fault_cond.hf_over;
  // (RULE8) clear blocked while high
  assign lfo_clr = {NCH{wr_lf_over}} & reg_req.wdata & ~fault_cond.lf_over;
  // (RULE11) unconditional clear
  assign seq_clr = {NCH{wr_poweron}} & reg_req.wdata;

  // ********************************************************
  // Sticky banks
  // ********************************************************
  logic [NCH-1:0] st_hfu;
  logic [NCH-1:0] st_lfu;
  logic [NCH-1:0] st_hfo;
  logic [NCH-1:0] st_lfo;
  logic [NCH-1:0] st_seq;
  // (RULE9) sticky latch banks
  cfs_fault_bank #(.CH_W(NCH)) u_hfu (.core_clk(core_clk), .rst(rst),
    .set_req(hfu_set), .clr_req(hfu_clr), .status(st_hfu));
  cfs_fault_bank #(.CH_W(NCH)) u_lfu (.core_clk(core_clk), .rst(rst),
    .set_req(lfu_set), .clr_req(lfu_clr), .status(st_lfu));
  cfs_fault_bank #(.CH_W(NCH)) u_hfo (.core_clk(core_clk), .rst(rst),
    .set_req(hfo_set), .clr_req(hfo_clr), .status(st_hfo));
  cfs_fault_bank #(.CH_W(NCH)) u_lfo (.core_clk(core_clk), .rst(rst),
    .set_req(lfo_set), .clr_req(lfo_clr), .status(st_lfo));
  cfs_fault_bank #(.CH_W(NCH)) u_seq (.core_clk(core_clk), .rst(rst),
    .set_req(seq_set), .clr_req(seq_clr), .status(st_seq));

  // ********************************************************
  // Enable masking and read mux
  // ********************************************************
  logic [NCH-1:0] vis_hfu;
  logic [NCH-1:0] vis_lfu;
  logic [NCH-1:0] vis_hfo;
  logic [NCH-1:0] vis_lfo;
  logic [NCH-1:0] vis_seq;
  logic [7:0] next_summary;
  logic any_fault;
  logic [7:0] next_rdata;
  // (RULE12) disabled bits hide
  assign vis_hfu = st_hfu & irq_enable.hf_under;
  assign vis_lfu = st_lfu & irq_enable.lf_under;
  assign vis_hfo = st_hfo & irq_enable.hf_over;
  assign vis_lfo = st_lfo & irq_enable.lf_over;
  assign vis_seq = st_seq & irq_enable.poweron;
  // (RULE14) (RULE15) per-type OR
  assign next_summary = {|vis_seq, 3'h0, |vis_lfo, |vis_hfo,
    |vis_lfu, |vis_hfu};
  // (RULE16) any enabled fault
  assign any_fault = |next_summary;
  // (RULE13) eight-bit read decode
  assign next_rdata =
    (reg_req.addr == cfs_pkg::OFS_HF_UNDER) ? vis_hfu :
    (reg_req.addr == cfs_pkg::OFS_LF_UNDER) ? vis_lfu :
    (reg_req.addr == cfs_pkg::OFS_HF_OVER) ? vis_hfo :
    (reg_req.addr == cfs_pkg::OFS_LF_OVER) ? vis_lfo :
    (reg_req.addr == cfs_pkg::OFS_POWERON_ORDER) ? vis_seq :
    (reg_req.addr == cfs_pkg::OFS_MONITOR_SUM) ? next_summary :
    8'h00;

  // ********************************************************
  // Output flops
  // ********************************************************
  // Read data holds until the next read so a slow engine can sample it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= cfs_pkg::RST_RDATA;
    end else if (reg_req.rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Summary and pin; the pin level stays low, the enable does the work
  always_ff @(posedge core_clk) begin
    if (rst) begin
      monitor_summary <= cfs_pkg::RST_STATUS;
      interrupt_out_n <= 1'b0;
      interrupt_out_n_oe_n <= 1'b1;
    end else begin
      monitor_summary <= next_summary;
      interrupt_out_n <= 1'b0;
      // (RULE16) pull pin low
      interrupt_out_n_oe_n <= ~any_fault;
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  logic [5*NCH-1:0] all_st;
  logic [NCH-1:0] hfu_blocked;
  logic [NCH-1:0] lfo_blocked;
  logic [NCH-1:0] lfu_blocked;
  logic [NCH-1:0] hfo_blocked;
  logic addr_mapped;
  logic [NCH-1:0] rd_mask;
  assign all_st = {st_hfu, st_lfu, st_hfo, st_lfo, st_seq};
  assign hfu_blocked = {NCH{wr_hf_under}} & reg_req.wdata
    & fault_cond.hf_under & st_hfu;
  assign lfo_blocked = {NCH{wr_lf_over}} & reg_req.wdata
    & fault_cond.lf_over & st_lfo;
  assign rd_mask = irq_enable.hf_under;
  assign lfu_blocked = {NCH{wr_lf_under}} & reg_req.wdata
    & fault_cond.lf_under & st_lfu;
  assign hfo_blocked = {NCH{wr_hf_over}} & reg_req.wdata
    & fault_cond.hf_over & st_hfo;
  // Offsets that hold a register; every other offset reads as zero
  assign addr_mapped = reg_req.addr inside {cfs_pkg::OFS_MONITOR_SUM,
    cfs_pkg::OFS_HF_UNDER, cfs_pkg::OFS_LF_UNDER, cfs_pkg::OFS_HF_OVER,
    cfs_pkg::OFS_LF_OVER, cfs_pkg::OFS_POWERON_ORDER};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Enabled conditions must latch at the very next edge
  AST_HFU_SET: assert property ( // RULE1
    hfu_set != 8'h00 |=> (st_hfu & $past(hfu_set)) == $past(hfu_set))
    else $error("HF under fault did not latch");
  AST_HFU_CLR_BLOCK: assert property ( // RULE2
    hfu_blocked != 8'h00 |=> (st_hfu & $past(hfu_blocked))
      == $past(hfu_blocked))
    else $error("HF under bit cleared while fault present");
  AST_LFU_SET: assert property ( // RULE3
    lfu_set != 8'h00 |=> (st_lfu & $past(lfu_set)) == $past(lfu_set))
    else $error("LF under fault did not latch");
  // Clears pass only for channels whose condition has gone
  AST_HFU_CLR_OK: assert property ( // RULE2
    (hfu_clr & ~hfu_set) != 8'h00
      |=> (st_hfu & $past(hfu_clr) & ~$past(hfu_set)) == 8'h00)
    else $error("Permitted HF under clear did not take effect");
  AST_LFU_CLR_OK: assert property ( // RULE4
    (lfu_clr & ~lfu_set) != 8'h00
      |=> (st_lfu & $past(lfu_clr) & ~$past(lfu_set)) == 8'h00)
    else $error("Permitted LF under clear did not take effect");
  AST_LFU_CLR_BLOCK: assert property ( // RULE4
    lfu_blocked != 8'h00 |=> (st_lfu & $past(lfu_blocked))
      == $past(lfu_blocked))
    else $error("LF under bit cleared while fault present");
  AST_HFO_SET: assert property ( // RULE5
    hfo_set != 8'h00 |=> (st_hfo & $past(hfo_set)) == $past(hfo_set))
    else $error("HF over fault did not latch");
  AST_LFO_SET: assert property ( // RULE7
    lfo_set != 8'h00 |=> (st_lfo & $past(lfo_set)) == $past(lfo_set))
    else $error("LF over fault did not latch");
  AST_LFO_CLR_BLOCK: assert property ( // RULE8
    lfo_blocked != 8'h00 |=> (st_lfo & $past(lfo_blocked))
      == $past(lfo_blocked))
    else $error("LF over bit cleared while fault present");
  // Overvoltage clears follow the same gating as undervoltage
  AST_HFO_CLR_BLOCK: assert property ( // RULE6
    hfo_blocked != 8'h00 |=> (st_hfo & $past(hfo_blocked))
      == $past(hfo_blocked))
    else $error("HF over bit cleared while fault present");
  AST_HFO_CLR_OK: assert property ( // RULE6
    (hfo_clr & ~hfo_set) != 8'h00
      |=> (st_hfo & $past(hfo_clr) & ~$past(hfo_set)) == 8'h00)
    else $error("Permitted HF over clear did not take effect");
  AST_LFO_CLR_OK: assert property ( // RULE8
    (lfo_clr & ~lfo_set) != 8'h00
      |=> (st_lfo & $past(lfo_clr) & ~$past(lfo_set)) == 8'h00)
    else $error("Permitted LF over clear did not take effect");
  AST_STICKY: assert property ( // RULE9
    !reg_req.wr |=> ($past(all_st) & ~all_st) == 40'h0)
    else $error("Fault bit fell without a host write");
  AST_SEQ_SET: assert property ( // RULE10
    seq_set != 8'h00 |=> (st_seq & $past(seq_set)) == $past(seq_set))
    else $error("Sequence mismatch did not latch");
  AST_SEQ_CLR: assert property ( // RULE11
    wr_poweron && !seq_check
      |=> (st_seq & $past(reg_req.wdata)) == 8'h00)
    else $error("Sequence bit survived write-1-to-clear");
  AST_MASKED_READ: assert property ( // RULE12
    reg_req.rd && reg_req.addr == cfs_pkg::OFS_HF_UNDER
      |=> (reg_rdata & ~$past(rd_mask)) == 8'h00)
    else $error("Disabled channel read back as set");
  AST_SUMMARY_HFU: assert property ( // RULE14
    ##1 monitor_summary[cfs_pkg::SUM_HF_UNDER] == $past(|vis_hfu))
    else $error("Summary bit 0 disagrees with HF under register");
  AST_SUMMARY_SEQ: assert property ( // RULE15
    ##1 monitor_summary[cfs_pkg::SUM_POWERON] == $past(|vis_seq))
    else $error("Summary bit 7 disagrees with sequence register");
  AST_IRQ_PIN: assert property ( // RULE16
    ##1 interrupt_out_n_oe_n == !$past(any_fault))
    else $error("Interrupt pin does not follow enabled faults");
  // Reserved offsets must not leak a neighbouring register
  AST_UNMAPPED_READ: assert property ( // RULE13
    reg_req.rd && !addr_mapped |=> reg_rdata == 8'h00)
    else $error("Unmapped offset read back nonzero");
  // Read data must hold for a slow engine between reads
  AST_READ_HOLD: assert property ( // RULE13
    !reg_req.rd |=> $stable(reg_rdata))
    else $error("Read data changed without a read");
  AST_SUMMARY_LFO: assert property ( // RULE14
    ##1 monitor_summary[cfs_pkg::SUM_LF_OVER] == $past(|vis_lfo))
    else $error("Summary bit 3 disagrees with LF over register");

  COV_BLOCKED_CLEAR: cover property (hfu_blocked != 8'h00);
  COV_SEQ_FAULT: cover property (seq_set != 8'h00 ##1 wr_poweron);
  COV_IRQ_CYCLE: cover property (
    !interrupt_out_n_oe_n ##1 interrupt_out_n_oe_n);
  COV_MASKED_READ: cover property (
    reg_req.rd && (st_hfu & ~irq_enable.hf_under) != 8'h00);
endmodule : cfs_fault_latches

// ===== test/cfs_host_model.sv
// Host model that strobes reads and clears into the fault latches
`timescale 1ns/10ps
module cfs_host_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output cfs_pkg::cfs_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata
);
  // ********************************************************
  // Strobe driver
  // ********************************************************
  // Idle before the first request
  initial begin
    reg_req = '0;
  end

  // Called just after a falling edge; the strobe lasts one cycle
  task automatic drive(input logic w, input logic r, input logic [7:0] a,
                       input logic [7:0] d);
    reg_req.wr = w;
    reg_req.rd = r;
    if (w || r) begin
      reg_req.addr = a;
      reg_req.wdata = d;
    end else begin
      // Idle bus inverts address and data, so a stale address comes back on every second idle cycle
      reg_req.addr = ~reg_req.addr;
      reg_req.wdata = ~reg_req.wdata;
    end
  endtask : drive
endmodule : cfs_host_model

// ===== test/channel_fault_status_latches_tb.sv
// Self-checking bench for the fault status latches with a sticky model
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module channel_fault_status_latches_tb;
  // ********************************************************
  // Signals
  // ********************************************************
  logic core_clk;
  logic rst;
  cfs_pkg::cfs_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  cfs_pkg::cfs_cond_t fault_cond;
  cfs_pkg::cfs_enable_t irq_enable;
  logic seq_check;
  logic [63:0] rec;
  logic [63:0] expd;
  logic [7:0] monitor_summary;
  logic interrupt_out_n;
  logic interrupt_out_n_oe_n;
  logic [7:0] st [5];
  logic [7:0] exp_rd;
  logic [7:0] exp_sum;
  logic exp_oe;
  logic [7:0] ofs [5] = '{8'h12, 8'h14, 8'h16, 8'h18, 8'h1A};
  int seed = 50279;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  // ********************************************************
  // Instances
  // ********************************************************
  cfs_fault_latches i_dut (
    .core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .fault_cond(fault_cond),
    .irq_enable(irq_enable), .seq_check(seq_check),
    .poweron_order_record(rec), .poweron_order_expected(expd),
    .monitor_summary(monitor_summary), .interrupt_out_n(interrupt_out_n),
    .interrupt_out_n_oe_n(interrupt_out_n_oe_n)
  );
  cfs_host_model i_host (
    .core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata)
  );

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ********************************************************
  // Reference model
  // ********************************************************
  // Set wins over clear; outputs lag the status by one edge
  always @(posedge core_clk) begin : ref_model
    logic [7:0] m, clr, setv, rdv, sum, mis;
    if (rst) begin
      for (int k = 0; k < 5; k++) st[k] <= 8'h00;
      exp_rd <= 8'h00;
      exp_sum <= 8'h00;
      exp_oe <= 1'b1;
    end else begin
      sum = 8'h00;
      rdv = 8'h00;
      for (int c = 0; c < 8; c++) mis[c] = rec[c*8 +: 8] != expd[c*8 +: 8];
      for (int k = 0; k < 5; k++) begin
        m = st[k] & irq_enable[39-8*k -: 8];
        sum[k == 4 ? 7 : k] = |m;
        if (reg_req.addr == ofs[k]) rdv = m;
        clr = (reg_req.wr && reg_req.addr == ofs[k]) ? reg_req.wdata : 8'h00;
        if (k < 4) begin
          clr = clr & ~fault_cond[31-8*k -: 8];
          setv = fault_cond[31-8*k -: 8];
        end else begin
          // unconditional clear, set again on mismatch
          setv = seq_check ? mis : 8'h00;
        end
        st[k] <= (st[k] & ~clr) | (setv & irq_enable[39-8*k -: 8]);
      end
      // summary also readable at its own offset
      if (reg_req.addr == 8'h11) rdv = sum;
      exp_sum <= sum;
      exp_oe <= ~|sum;
      if (reg_req.rd) exp_rd <= rdv;
    end
  end

  // ********************************************************
  // Closing and timeout
  // ********************************************************
  task automatic results();
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // Ceiling well above the 3000-cycle run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      results();
    end
  end

  // ********************************************************
  // Stimulus and comparison
  // ********************************************************
  initial begin : stim
    logic [7:0] a;
    logic w, r;
    rst = 1'b1;
    fault_cond = '0;
    irq_enable = '0;
    seq_check = 1'b0;
    rec = '0;
    expd = '0;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      `CHK("reg_rdata", exp_rd, reg_rdata)
      `CHK("monitor_summary", exp_sum, monitor_summary)
      `CHK("interrupt_out_n_oe_n", exp_oe, interrupt_out_n_oe_n)
      `CHK("interrupt_out_n", 1'b0, interrupt_out_n)
      // Two-cycle reset every 1000 cycles, three times in the run
      rst = (i % 1000) >= 998;
      // Sparse faults so that clears often succeed
      fault_cond = $random(seed) & $random(seed) & $random(seed);
      if (i % 64 == 0) begin
        irq_enable = 40'({$random(seed), $random(seed)} |
                         {$random(seed), $random(seed)});
      end
      seq_check = ($random(seed) & 15) == 0;
      rec = {$random(seed), $random(seed)};
      expd = rec;
      for (int c = 0; c < 8; c++) begin
        if (($random(seed) & 3) == 0) expd[c*8] = ~rec[c*8];
      end
      a = 8'h10 + 8'($random(seed) & 15);
      w = ($random(seed) & 3) == 0;
      r = ($random(seed) & 3) == 0;
      i_host.drive(w, r, a, 8'($random(seed)));
    end
    results();
  end
endmodule : channel_fault_status_latches_tb
